// ==== bus_arb_pkg.sv ====
// shared constants and types for the memory bus arbiter
package bus_arb_pkg;
   localparam int PROG_ADDR_W = 22;
   localparam int DATA_ADDR_W = 32;
   localparam int WORD_W = 32;
   localparam int PERIPH_ADDR_W = 16;
   localparam int HALF_W = 16;
   localparam int NUM_REQ = 5;
   // request indices, highest priority first
   localparam int REQ_DWR = 0;
   localparam int REQ_PWR = 1;
   localparam int REQ_DRD = 2;
   localparam int REQ_PRD = 3;
   localparam int REQ_FETCH = 4;
   localparam logic [4:0] GRANT_RESET = 5'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [15:0] HALF_RESET = 16'h0000;
   // peripheral frame variants
   typedef enum logic [1:0] {FRAME_NONE, FRAME_ONE, FRAME_TWO, FRAME_THREE}
      frame_t;
   typedef enum {BR_IDLE, BR_ACCESS} bridge_state_t;
endpackage

// ==== prio_pick.sv ====
// fixed priority one-hot picker
`timescale 1ns/10ps
module prio_pick
   import bus_arb_pkg::*;
#(
   parameter int N = NUM_REQ
)
(
   input wire logic [N-1:0] req,
   output logic [N-1:0] gnt
);
   logic [N-1:0] higher;

   // bit 0 is highest priority
   assign higher[0] = 1'b0;
   genvar i;
   generate
      for (i = 1; i < N; i++)
      begin : g_chain
         assign higher[i] = higher[i-1] | req[i-1];
      end
   endgenerate

   assign gnt = req & ~higher;
endmodule

// ==== frame_check.sv ====
// legal-width check for one peripheral frame access
`timescale 1ns/10ps
module frame_check
   import bus_arb_pkg::*;
(
   input wire frame_t frame,
   input wire logic wide,
   input wire logic from_dma,
   output logic ok
);
   always_comb
   begin
      case (frame)
         FRAME_ONE: ok = ~from_dma;
         FRAME_TWO: ok = ~wide & ~from_dma;
         FRAME_THREE: ok = 1'b1;
         default: ok = 1'b0;
      endcase
   end
endmodule

// ==== mem_bus_arbiter.sv ====
// memory bus priority arbiter with peripheral bridge
// Functional notes
// - The program bus carries a 22-bit address and a 32-bit word.
// - Data read and write buses carry 32-bit address and 32-bit data.
// - At most two requests complete in one cycle: one on memory, one on the bridge.
// - Priority: data write, program write, data read, program read, fetch.
// - Data write and program write never share the memory bus in a cycle.
// - Program read and fetch never share the memory bus in a cycle.
// - The bridge muxes onto one bus with 16-bit address, 16/32-bit data.
// - Frame two takes 16-bit transfers only.
// - Frame one takes 16-bit and 32-bit transfers from the processor.
// - Frame three takes 16/32-bit transfers and is reachable by DMA.
`timescale 1ns/10ps
module mem_bus_arbiter
   import bus_arb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // program read/write bus, write data shares the data write bus
   input wire logic prd_req,
   input wire logic pwr_req,
   input wire logic fetch_req,
   input wire logic [PROG_ADDR_W-1:0] prog_addr,
   input wire logic [PROG_ADDR_W-1:0] fetch_addr,
   output logic [WORD_W-1:0] prog_rdata,
   // data read bus
   input wire logic drd_req,
   input wire logic [DATA_ADDR_W-1:0] drd_addr,
   output logic [WORD_W-1:0] drd_rdata,
   // data write bus
   input wire logic dwr_req,
   input wire logic [DATA_ADDR_W-1:0] dwr_addr,
   input wire logic [WORD_W-1:0] dwr_wdata,
   // access width for peripheral targets, 1 = 32 bit
   input wire logic wide,
   // dma port into frame three
   input wire logic dma_req,
   input wire logic dma_wr,
   input wire logic dma_wide,
   input wire logic [PERIPH_ADDR_W-1:0] dma_addr,
   input wire logic [WORD_W-1:0] dma_wdata,
   // target select from address decode, one per request
   input wire logic [NUM_REQ-1:0] periph_sel,
   input wire frame_t frame,
   // memory side
   output logic mem_en,
   output logic mem_wr,
   output logic [DATA_ADDR_W-1:0] mem_addr,
   output logic [WORD_W-1:0] mem_wdata,
   input wire logic [WORD_W-1:0] mem_rdata,
   // peripheral bus
   output logic per_en,
   output logic per_wr,
   output logic per_wide,
   output frame_t per_frame,
   output logic [PERIPH_ADDR_W-1:0] per_addr,
   output logic [WORD_W-1:0] per_wdata,
   input wire logic [WORD_W-1:0] per_rdata,
   output logic per_err,
   // grant status, one bit per request
   output logic [NUM_REQ-1:0] grant,
   output logic [NUM_REQ-1:0] pending,
   output logic dma_grant
);
   // =================================
   // request collection
   // =================================
   logic [NUM_REQ-1:0] req_vec;
   logic [NUM_REQ-1:0] mem_req;
   logic [NUM_REQ-1:0] per_req;
   logic [NUM_REQ-1:0] mem_gnt;
   logic [NUM_REQ-1:0] per_gnt;
   logic [NUM_REQ-1:0] pend_reg;
   logic [NUM_REQ-1:0] pend_next;
   logic [DATA_ADDR_W-1:0] addr_of [NUM_REQ];

   always_comb
   begin
      req_vec = {fetch_req, prd_req, drd_req, pwr_req, dwr_req} | pend_reg;
      mem_req = req_vec & ~periph_sel;
      per_req = req_vec & periph_sel;
   end

   assign addr_of[REQ_DWR] = dwr_addr;
   assign addr_of[REQ_PWR] = {{(DATA_ADDR_W-PROG_ADDR_W){1'b0}}, prog_addr};
   assign addr_of[REQ_DRD] = drd_addr;
   assign addr_of[REQ_PRD] = {{(DATA_ADDR_W-PROG_ADDR_W){1'b0}}, prog_addr};
   assign addr_of[REQ_FETCH] = {{(DATA_ADDR_W-PROG_ADDR_W){1'b0}},
      fetch_addr};

   // one grant per target; memory and peripheral run side by side
   prio_pick #(.N(NUM_REQ)) u_mem_pick
   (
      .req(mem_req),
      .gnt(mem_gnt)
   );

   prio_pick #(.N(NUM_REQ)) u_per_pick
   (
      .req(per_req),
      .gnt(per_gnt)
   );

   // =================================
   // pending hold
   // =================================
   always_comb
   begin
      pend_next = req_vec & ~(mem_gnt | per_gnt);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pend_reg <= GRANT_RESET;
      else
         pend_reg <= pend_next;
   end

   // =================================
   // memory port
   // =================================
   logic mem_en_next;
   logic mem_wr_next;
   logic [DATA_ADDR_W-1:0] mem_addr_next;
   logic [WORD_W-1:0] mem_wdata_next;
   logic [NUM_REQ-1:0] mem_last_reg;
   logic [WORD_W-1:0] prog_rdata_next;
   logic [WORD_W-1:0] drd_rdata_next;
   logic mem_en_reg;
   logic mem_wr_reg;
   logic [DATA_ADDR_W-1:0] mem_addr_reg;
   logic [WORD_W-1:0] mem_wdata_reg;
   logic [WORD_W-1:0] prog_rdata_reg;
   logic [WORD_W-1:0] drd_rdata_reg;
   logic [NUM_REQ-1:0] grant_next;
   logic [NUM_REQ-1:0] grant_reg;

   always_comb
   begin
      mem_en_next = |mem_gnt;
      mem_wr_next = mem_gnt[REQ_DWR] | mem_gnt[REQ_PWR];
      mem_addr_next = WORD_RESET;
      for (int k = 0; k < NUM_REQ; k++)
         if (mem_gnt[k])
            mem_addr_next = addr_of[k];
      mem_wdata_next = mem_wr_next ? dwr_wdata : WORD_RESET;
   end

   // =================================
   // peripheral bridge
   // =================================
   bridge_state_t br_reg;
   bridge_state_t br_next;
   logic per_en_next;
   logic per_wr_next;
   logic per_wide_next;
   frame_t per_frame_next;
   logic [PERIPH_ADDR_W-1:0] per_addr_next;
   logic [WORD_W-1:0] per_wdata_next;
   logic per_err_next;
   logic dma_grant_next;
   logic [NUM_REQ-1:0] per_last_reg;
   logic cpu_ok;
   logic dma_ok;
   logic per_en_reg;
   logic per_wr_reg;
   logic per_wide_reg;
   frame_t per_frame_reg;
   logic [PERIPH_ADDR_W-1:0] per_addr_reg;
   logic [WORD_W-1:0] per_wdata_reg;
   logic per_err_reg;
   logic dma_grant_reg;

   frame_check u_cpu_check
   (
      .frame(frame),
      .wide(wide),
      .from_dma(1'b0),
      .ok(cpu_ok)
   );

   frame_check u_dma_check
   (
      .frame(FRAME_THREE),
      .wide(dma_wide),
      .from_dma(1'b1),
      .ok(dma_ok)
   );

   always_comb
   begin
      br_next = BR_IDLE;
      per_en_next = 1'b0;
      per_wr_next = 1'b0;
      per_wide_next = 1'b0;
      per_frame_next = FRAME_NONE;
      per_addr_next = HALF_RESET;
      per_wdata_next = WORD_RESET;
      per_err_next = 1'b0;
      dma_grant_next = 1'b0;
      case (br_reg)
         BR_IDLE,
         BR_ACCESS:
         begin
            if (|per_gnt)
            begin
               br_next = BR_ACCESS;
               if (cpu_ok)
               begin
                  per_en_next = 1'b1;
                  per_wr_next = per_gnt[REQ_DWR] | per_gnt[REQ_PWR];
                  per_wide_next = wide;
                  per_frame_next = frame;
                  for (int k = 0; k < NUM_REQ; k++)
                     if (per_gnt[k])
                        per_addr_next = addr_of[k][PERIPH_ADDR_W-1:0];
                  per_wdata_next = per_wr_next ? dwr_wdata : WORD_RESET;
               end
               else
                  per_err_next = 1'b1;
            end
            else if (dma_req && dma_ok)
            begin
               br_next = BR_ACCESS;
               per_en_next = 1'b1;
               per_wr_next = dma_wr;
               per_wide_next = dma_wide;
               per_frame_next = FRAME_THREE;
               per_addr_next = dma_addr;
               per_wdata_next = dma_wr ? dma_wdata : WORD_RESET;
               dma_grant_next = 1'b1;
            end
         end
         default:
            br_next = BR_IDLE;
      endcase
   end

   // =================================
   // read return
   // =================================
   always_comb
   begin
      grant_next = mem_gnt | (per_gnt & {NUM_REQ{cpu_ok}});
      prog_rdata_next = prog_rdata_reg;
      drd_rdata_next = drd_rdata_reg;
      if (mem_last_reg[REQ_PRD] || mem_last_reg[REQ_FETCH])
         prog_rdata_next = mem_rdata;
      if (per_last_reg[REQ_PRD] || per_last_reg[REQ_FETCH])
         prog_rdata_next = per_rdata;
      if (mem_last_reg[REQ_DRD])
         drd_rdata_next = mem_rdata;
      if (per_last_reg[REQ_DRD])
         drd_rdata_next = per_wide_reg ? per_rdata
            : {HALF_RESET, per_rdata[HALF_W-1:0]};
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mem_en_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         mem_addr_reg <= WORD_RESET;
         mem_wdata_reg <= WORD_RESET;
         mem_last_reg <= GRANT_RESET;
         per_last_reg <= GRANT_RESET;
         grant_reg <= GRANT_RESET;
         prog_rdata_reg <= WORD_RESET;
         drd_rdata_reg <= WORD_RESET;
         br_reg <= BR_IDLE;
         per_en_reg <= 1'b0;
         per_wr_reg <= 1'b0;
         per_wide_reg <= 1'b0;
         per_frame_reg <= FRAME_NONE;
         per_addr_reg <= HALF_RESET;
         per_wdata_reg <= WORD_RESET;
         per_err_reg <= 1'b0;
         dma_grant_reg <= 1'b0;
      end
      else
      begin
         mem_en_reg <= mem_en_next;
         mem_wr_reg <= mem_wr_next;
         mem_addr_reg <= mem_addr_next;
         mem_wdata_reg <= mem_wdata_next;
         mem_last_reg <= mem_gnt;
         per_last_reg <= per_gnt & {NUM_REQ{cpu_ok}};
         grant_reg <= grant_next;
         prog_rdata_reg <= prog_rdata_next;
         drd_rdata_reg <= drd_rdata_next;
         br_reg <= br_next;
         per_en_reg <= per_en_next;
         per_wr_reg <= per_wr_next;
         per_wide_reg <= per_wide_next;
         per_frame_reg <= per_frame_next;
         per_addr_reg <= per_addr_next;
         per_wdata_reg <= per_wdata_next;
         per_err_reg <= per_err_next;
         dma_grant_reg <= dma_grant_next;
      end
   end

   assign mem_en = mem_en_reg;
   assign mem_wr = mem_wr_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign prog_rdata = prog_rdata_reg;
   assign drd_rdata = drd_rdata_reg;
   assign per_en = per_en_reg;
   assign per_wr = per_wr_reg;
   assign per_wide = per_wide_reg;
   assign per_frame = per_frame_reg;
   assign per_addr = per_addr_reg;
   assign per_wdata = per_wdata_reg;
   assign per_err = per_err_reg;
   assign grant = grant_reg;
   assign pending = pend_reg;
   assign dma_grant = dma_grant_reg;
endmodule

// ==== mem_bus_arbiter_assertions.sv ====
// assertion checker for the memory bus arbiter
`timescale 1ns/10ps
module mem_bus_arbiter_chk
   import bus_arb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic dwr_req,
   input wire logic pwr_req,
   input wire logic drd_req,
   input wire logic prd_req,
   input wire logic fetch_req,
   input wire logic [DATA_ADDR_W-1:0] dwr_addr,
   input wire logic [WORD_W-1:0] dwr_wdata,
   input wire logic [DATA_ADDR_W-1:0] drd_addr,
   input wire logic [PROG_ADDR_W-1:0] fetch_addr,
   input wire logic [NUM_REQ-1:0] periph_sel,
   input wire frame_t frame,
   input wire logic wide,
   input wire logic dma_req,
   input wire logic dma_wide,
   input wire logic [PERIPH_ADDR_W-1:0] dma_addr,
   input wire logic mem_en,
   input wire logic mem_wr,
   input wire logic [DATA_ADDR_W-1:0] mem_addr,
   input wire logic [WORD_W-1:0] mem_wdata,
   input wire logic per_en,
   input wire logic per_wr,
   input wire logic per_wide,
   input wire frame_t per_frame,
   input wire logic [PERIPH_ADDR_W-1:0] per_addr,
   input wire logic per_err,
   input wire logic [NUM_REQ-1:0] grant,
   input wire logic [NUM_REQ-1:0] pending
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
wire no_cpu = !(dwr_req | pwr_req | drd_req | prd_req | fetch_req);
wire calm = pending == 5'h00 && !pwr_req;
sequence loser_served;
   pending[REQ_DRD] ##1 (mem_en && !mem_wr && mem_addr == $past(drd_addr, 2));
endsequence
AST_WR_FIRST: assert property (dwr_req && !periph_sel[REQ_DWR] |=>
   mem_en && mem_wr && mem_wdata == $past(dwr_wdata))
   else $error("write lost");
AST_LOSER: assert property (dwr_req && drd_req && calm &&
   periph_sel == 5'h00 |=> loser_served) else $error("loser not served");
AST_NO_TWO_WR: assert property (!(grant[REQ_DWR] && grant[REQ_PWR]))
   else $error("two writes at once");
AST_NO_TWO_RD: assert property (!(grant[REQ_PRD] && grant[REQ_FETCH]))
   else $error("read and fetch at once");
AST_CONCUR: assert property (dwr_req && drd_req && calm &&
   periph_sel == 5'h04 && frame == FRAME_ONE |=> mem_en && per_en && !per_wr)
   else $error("no concurrent access");
AST_FRAME_TWO: assert property (per_en && per_frame == FRAME_TWO |->
   !per_wide) else $error("wide access on frame two");
AST_FRAME_ONE: assert property (drd_req && !dwr_req && calm && wide &&
   periph_sel == 5'h04 && frame == FRAME_ONE |=>
   per_en && per_wide && !per_err) else $error("wide frame one refused");
AST_DMA: assert property (dma_req && no_cpu && pending == 5'h00 |=>
   per_en && per_frame == FRAME_THREE && per_wide == $past(dma_wide) &&
   per_addr == $past(dma_addr)) else $error("dma access wrong");
AST_FETCH: assert property (mem_en && grant == 5'h10 |-> !mem_wr &&
   mem_addr[PROG_ADDR_W-1:0] == $past(fetch_addr)) else $error("bad fetch");
endmodule

bind mem_bus_arbiter mem_bus_arbiter_chk chk_i (.*);

// ==== mem_bus_partner.sv ====
// memories and peripherals answering the arbiter
`timescale 1ns/10ps
module mem_bus_partner
   import bus_arb_pkg::*;
#(
   parameter logic [31:0] MEM_KEY = 32'h5a5a_5a5a,
   parameter logic [31:0] PER_KEY = 32'h0f0f_0f0f
)
(
   input wire logic clk,
   input wire logic mem_en,
   input wire logic [DATA_ADDR_W-1:0] mem_addr,
   output logic [WORD_W-1:0] mem_rdata,
   input wire logic per_en,
   input wire logic [PERIPH_ADDR_W-1:0] per_addr,
   output logic [WORD_W-1:0] per_rdata
);
logic [WORD_W-1:0] m_reg = 32'h0000_0000;
logic [WORD_W-1:0] p_reg = 32'h0000_0000;
logic m_hold = 1'b0;
logic p_hold = 1'b0;
always @(posedge clk)
begin
   m_hold <= mem_en;
   p_hold <= per_en;
   if (mem_en)
      m_reg <= mem_addr ^ MEM_KEY;
   if (per_en)
      p_reg <= {16'h0000, per_addr} ^ PER_KEY;
end
// data valid in strobe cycle and the next, scrambled after
assign mem_rdata = mem_en ? mem_addr ^ MEM_KEY :
   (m_hold ? m_reg : ~m_reg);
assign per_rdata = per_en ? {16'h0000, per_addr} ^ PER_KEY :
   (p_hold ? p_reg : ~p_reg);
endmodule

// ==== memory_bus_priority_arbiter_tb_top.sv ====
// self-checking bench for the memory bus arbiter
`timescale 1ns/10ps
module memory_bus_priority_arbiter_tb_top
   import bus_arb_pkg::*;
();
localparam logic [31:0] MK = 32'h5a5a_5a5a;
localparam logic [31:0] PK = 32'h0f0f_0f0f;
logic clk, rst, prd_req, pwr_req, fetch_req, drd_req, dwr_req, wide;
logic dma_req, dma_wr, dma_wide, mem_en, mem_wr, per_en, per_wr, per_wide;
logic per_err, dma_grant;
logic [PROG_ADDR_W-1:0] prog_addr, fetch_addr;
logic [31:0] drd_addr, dwr_addr, dwr_wdata, dma_wdata, mem_addr, mem_wdata;
logic [31:0] prog_rdata, drd_rdata, mem_rdata, per_wdata, per_rdata;
logic [15:0] dma_addr, per_addr;
logic [4:0] periph_sel, grant, pending;
frame_t frame, per_frame;
int error_cnt = 0;
int n_compared = 0;
int cyc = 0;
mem_bus_arbiter dut (.*);
mem_bus_partner #(.MEM_KEY(MK), .PER_KEY(PK)) far (.*);
initial
begin
   clk = 1'b0;
   forever #2 clk = ~clk;
end
always @(posedge clk)
begin
   cyc++;
   if (cyc == 3000)
   begin
      error_cnt++;
      complete_run();
   end
end
task automatic chk(input string what, input logic [31:0] exp, got);
begin
   n_compared++;
   if (got !== exp)
   begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
   end
end
endtask
task complete_run();
begin
   $display("compared %0d mismatches %0d", n_compared, error_cnt);
   if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
   else
      $display("Regression broken");
   $finish;
end
endtask
// ====
// all five requests at once, served by priority
task s_order();
   logic [21:0] ea [5];
begin
   ea = '{22'h00_1111, 22'h03_3333, 22'h00_2222, 22'h03_3333, 22'h04_4444};
   {dwr_req, pwr_req, drd_req, prd_req, fetch_req} = 5'h1f;
   for (int i = 0; i < 5; i++)
   begin
      @(negedge clk);
      {dwr_req, pwr_req, drd_req, prd_req, fetch_req} = 5'h00;
      chk("mem_en", 1'b1, mem_en);
      chk("mem_wr", i < 2, mem_wr);
      chk("mem_addr", ea[i], mem_addr[21:0]);
      chk("grant", 5'h01 << i, grant);
      if (i == 0)
         chk("mem_wdata", dwr_wdata, mem_wdata);
   end
   repeat (3) @(negedge clk);
   chk("drd_rdata", 32'h0000_2222 ^ MK, drd_rdata);
   chk("prog_rdata", 22'h04_4444 ^ MK[21:0], prog_rdata[21:0]);
end
endtask
// write and read to memory together, read waits one cycle
task s_loser();
begin
   drd_addr = 32'h0000_6666;
   {dwr_req, drd_req} = 2'b11;
   @(negedge clk);
   {dwr_req, drd_req} = 2'b00;
   chk("grant", 5'h01, grant);
   chk("pending", 5'h04, pending);
   @(negedge clk);
   chk("grant", 5'h04, grant);
   chk("mem_addr", 32'h0000_6666, mem_addr);
   chk("pending", 5'h00, pending);
   @(negedge clk);
   chk("drd_rdata", 32'h0000_6666 ^ MK, drd_rdata);
   drd_addr = 32'h0000_2222;
end
endtask
// memory write beside peripheral read
task s_concur();
begin
   {dwr_req, drd_req, periph_sel} = {2'b11, 5'h04};
   frame = FRAME_ONE;
   @(negedge clk);
   {dwr_req, drd_req} = 2'b00;
   chk("mem_wr", 1'b1, mem_en & mem_wr);
   chk("per_rd", 1'b1, per_en & !per_wr);
   chk("per_addr", 16'h2222, per_addr);
   repeat (3) @(negedge clk);
   chk("drd_rdata", {16'h0000, 16'h2222 ^ PK[15:0]}, drd_rdata);
end
endtask
// every frame with both widths
task s_widths();
begin
   for (int f = 0; f < 4; f++)
      for (int w = 0; w < 2; w++)
      begin
         {drd_req, wide} = {1'b1, w[0]};
         frame = frame_t'(f);
         @(negedge clk);
         drd_req = 1'b0;
         chk("per_en", f != 0 && !(f == 2 && w == 1), per_en);
         chk("per_err", f == 0 || (f == 2 && w == 1), per_err);
         @(negedge clk);
      end
end
endtask
// dma waits for the cpu, then reaches frame three
task s_dma();
begin
   {dma_req, dma_wr, dma_wide, drd_req} = 4'hf;
   frame = FRAME_ONE;
   @(negedge clk);
   drd_req = 1'b0;
   chk("dma_grant", 1'b0, dma_grant);
   for (int k = 0; k < 4 && dma_grant !== 1'b1; k++)
      @(negedge clk);
   dma_req = 1'b0;
   chk("dma_grant", 1'b1, dma_grant);
   chk("per_frame", FRAME_THREE, per_frame);
   chk("per_wide", 1'b1, per_wide & per_wr);
   chk("per_addr", dma_addr, per_addr);
   chk("per_wdata", dma_wdata, per_wdata);
end
endtask
initial
begin
   rst = 1'b1;
   {prd_req, pwr_req, fetch_req, drd_req, dwr_req, wide} = 6'h00;
   {dma_req, dma_wr, dma_wide, periph_sel} = 8'h00;
   frame = FRAME_NONE;
   {dwr_addr, drd_addr} = {32'h0000_1111, 32'h0000_2222};
   {prog_addr, fetch_addr} = {22'h03_3333, 22'h04_4444};
   {dwr_wdata, dma_wdata, dma_addr} = {32'hcafe_0001, 32'h1234_5678, 16'h0055};
   repeat (12) @(negedge clk);
   rst = 1'b0;
   @(negedge clk);
   s_order();
   s_loser();
   s_concur();
   s_widths();
   s_dma();
   repeat (4) @(negedge clk);
   complete_run();
end
endmodule
